// File: logic/host_port_pkg.sv
// Shared constants and types for the host port detector and serial slave
package host_port_pkg;
    // Host interface kinds chosen from the straps
    typedef enum logic [2:0] {
        HOST_NONE,
        HOST_PAR_DED,
        HOST_PAR_MUX_SEP,
        HOST_PAR_MUX_COM,
        HOST_UART,
        HOST_SPI,
        HOST_I2C
    } host_mode_e;

    localparam int          BYTE_W       = 8;
    localparam int          REG_ADDR_W   = 6;
    localparam int          DIR_BIT      = 7;
    localparam int          ADDR_MSB     = 6;
    localparam int          ADDR_LSB     = 1;
    localparam logic [5:0]  STRAP_UART   = 6'h00;
    localparam logic [5:0]  STRAP_SPI    = 6'h01;
    localparam logic [5:0]  STRAP_I2C_M  = 6'h3E;
    localparam logic [5:0]  STRAP_I2C    = 6'h02;
    localparam logic [5:0]  STRAP_MUX_M  = 6'h3F;
    localparam logic [5:0]  STRAP_MUX_S  = 6'h07;
    localparam logic [5:0]  STRAP_MUX_C  = 6'h06;
    localparam logic [7:0]  MISO_IDLE    = 8'h00;
    localparam int          FIFO_DEPTH   = 4;
    localparam int          SYS_FREQ_HZ  = 25_000_000;
    localparam int          LINK_MAX_BPS = 10_000_000;
    localparam int          SETTLE_CYC   = 2;
endpackage

// File: logic/reg_req_if.sv
// Register request carrier between the serial slave and its request FIFO
`timescale 1ns/1ps
interface reg_req_if #(parameter int W = 15);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: logic/req_fifo.sv
// Small valid/ready FIFO for register requests
`timescale 1ns/1ps
module req_fifo #(
    parameter int W     = 15,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    // Fill side
    reg_req_if.snk            in_p,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("req_fifo depth must be a power of two, at least 2");
        end
    end

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } fifo_s;

    fifo_s        st_q;
    fifo_s        st_d;
    logic [W-1:0] mem_q [DEPTH];
    logic         full;
    logic         empty;
    logic         push;
    logic         pop;

    // Full when pointers differ only in the wrap bit
    assign empty     = (st_q.wr == st_q.rd);
    assign full      = (st_q.wr[AW-1:0] == st_q.rd[AW-1:0]) && (st_q.wr[AW] != st_q.rd[AW]);
    assign in_p.ready = !full;
    assign out_valid = !empty;
    assign out_data  = mem_q[st_q.rd[AW-1:0]];
    assign push      = in_p.valid && !full;
    assign pop       = out_ready && !empty;

    // Pointer update
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.wr = st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = st_q.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Storage needs no reset; empty masks stale words
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[st_q.wr[AW-1:0]] <= in_p.data;
        end
    end
endmodule

// File: logic/pin_sync.sv
// Two-stage synchroniser bank for pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    // Pins in, synchronised out
    input  wire logic [W-1:0] pin_in,
    output logic [W-1:0]      pin_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_out = sync_q;
endmodule

// File: logic/host_port_detect_spi_slave.sv
// Host port strap detection and serial register slave
// What this block does
// - Redetect host interface after every reset
// - Sample straps after reset, hold until reset
// - Serial modes from strobes and A5..A0 straps
// - Parallel modes from latch pin and straps
// - Map shared pins in SPI mode only; UART and I2C leave them unused
// - Take bytes on MOSI, return on MISO
// - All bytes shifted most significant bit first
// - Update MISO on falling clock edge
// - Read burst returns previous address data
// - Write burst output is MISO_IDLE throughout
// - Address byte bit 7: read one, write zero
// - Register address in address bits 6..1
`timescale 1ns/1ps
module host_port_detect_spi_slave
    import host_port_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // Strap and shared host pins
    input  wire logic             latch_pin,
    input  wire logic [5:0]       addr_strap,
    input  wire logic             read_strobe_n,
    input  wire logic             write_strobe_n,
    input  wire logic [6:5]       data_pin_in,
    output logic                  miso_out,
    output logic                  miso_oe,
    // Detection result
    output host_mode_e            host_mode,
    output logic                  mode_valid,
    output logic                  i2c_addr_extension_strap,
    // Register access toward the core
    output logic                  reg_req_valid,
    input  wire logic             reg_req_ready,
    output logic                  reg_req_write,
    output logic [REG_ADDR_W-1:0] reg_req_addr,
    output logic [BYTE_W-1:0]     reg_req_wdata,
    input  wire logic             reg_rd_valid,
    input  wire logic [BYTE_W-1:0] reg_rd_data
);
    localparam int REQ_W = 1 + REG_ADDR_W + BYTE_W;
    // Link must give at least one system cycle per clock half for edge finding
    localparam int MIN_HALF_CYC = SYS_FREQ_HZ / (2 * LINK_MAX_BPS);

    initial begin
        if (DEPTH < 2) begin
            $error("request FIFO depth must be at least 2");
        end
        if (MIN_HALF_CYC < 1) begin
            $error("system clock too slow for the serial link rate");
        end
    end

    typedef enum logic [1:0] {
        ST_SETTLE,
        ST_RUN
    } top_state_e;

    typedef struct packed {
        top_state_e                state;
        logic [1:0]                settle;
        host_mode_e                mode;
        logic                      ea;
        logic                      sck_prev;
        logic                      ss_prev;
        logic [2:0]                bit_cnt;
        logic                      first;
        logic                      is_read;
        logic [REG_ADDR_W-1:0]     waddr;
        logic [BYTE_W-1:0]         rx_sh;
        logic [BYTE_W-1:0]         tx_sh;
        logic [BYTE_W-1:0]         rd_buf;
        logic                      miso;
        logic                      miso_oe;
        logic                      push;
        logic [REQ_W-1:0]          push_data;
        logic                      req_valid;
        logic [REQ_W-1:0]          req_data;
    } state_s;

    state_s      st_q;
    state_s      st_d;
    logic [9:0]  pins_s;
    logic        latch_s;
    logic [5:0]  strap_s;
    logic        rdn_s;
    logic        wrn_s;
    logic        mosi_s;
    logic        sck_s;
    logic        sck_rise;
    logic        sck_fall;
    logic        ss_fall;
    logic        ss_act;
    logic        spi_on;
    logic        f_valid;
    logic        f_ready;
    logic [REQ_W-1:0] f_data;
    logic [BYTE_W-1:0] rx_byte;

    reg_req_if #(.W(REQ_W)) req_bus ();

    // Every pin passes two flops before use
    pin_sync #(.W(10)) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin_in  ({latch_pin, addr_strap, read_strobe_n, write_strobe_n, data_pin_in[5]}),
        .pin_out (pins_s)
    );

    pin_sync #(.W(1)) u_sync_mosi (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin_in  (data_pin_in[6]),
        .pin_out (mosi_s)
    );

    assign latch_s = pins_s[9];
    assign strap_s = pins_s[8:3];
    assign rdn_s   = pins_s[2];
    assign wrn_s   = pins_s[1];
    assign sck_s   = pins_s[0];

    // Request queue decouples burst bytes from core back-pressure
    assign req_bus.valid = st_q.push;
    assign req_bus.data  = st_q.push_data;

    req_fifo #(.W(REQ_W), .DEPTH(DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_p      (req_bus),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // Output stage is registered; take a new word only when empty or consumed
    assign f_ready = !st_q.req_valid || reg_req_ready;

    // Edge detection on synchronised link pins
    assign sck_rise = sck_s && !st_q.sck_prev;
    assign sck_fall = !sck_s && st_q.sck_prev;
    assign ss_act   = !latch_s;
    assign ss_fall  = !latch_s && st_q.ss_prev;
    assign spi_on   = (st_q.state == ST_RUN) && (st_q.mode == HOST_SPI);
    assign rx_byte  = {st_q.rx_sh[BYTE_W-2:0], mosi_s};

    always_comb begin
        st_d          = st_q;
        st_d.sck_prev = sck_s;
        st_d.ss_prev  = latch_s;
        st_d.push     = 1'b0;
        case (st_q.state)
            // Let the synchronisers fill before sampling straps
            ST_SETTLE: begin
                st_d.settle = st_q.settle + 2'h1;
                if (st_q.settle == 2'(SETTLE_CYC)) begin
                    st_d.state = ST_RUN;
                    st_d.ea    = 1'b0;
                    if (latch_s) begin
                        st_d.mode = HOST_PAR_DED;
                    end else if (!rdn_s || !wrn_s) begin
                        st_d.mode = HOST_NONE;
                    end else if (strap_s == STRAP_MUX_S) begin
                        st_d.mode = HOST_PAR_MUX_SEP;
                    end else if (strap_s == STRAP_MUX_C) begin
                        st_d.mode = HOST_PAR_MUX_COM;
                    end else if (strap_s == STRAP_UART) begin
                        st_d.mode = HOST_UART;
                    end else if (strap_s == STRAP_SPI) begin
                        st_d.mode = HOST_SPI;
                    end else if ((strap_s & STRAP_I2C_M) == STRAP_I2C) begin
                        st_d.mode = HOST_I2C;
                        st_d.ea   = strap_s[0];
                    end else begin
                        st_d.mode = HOST_NONE;
                    end
                end
            end
            // Mode frozen until next reset
            ST_RUN: begin
                if (spi_on) begin
                    st_d.miso_oe = ss_act;
                    if (ss_fall) begin
                        st_d.bit_cnt = 3'h0;
                        st_d.first   = 1'b1;
                        st_d.tx_sh   = MISO_IDLE;
                        st_d.miso    = 1'b0;
                    end else if (!ss_act) begin
                        st_d.first   = 1'b1;
                        st_d.bit_cnt = 3'h0;
                    end else begin
                        if (sck_rise) begin
                            st_d.rx_sh   = rx_byte;
                            st_d.bit_cnt = st_q.bit_cnt + 3'h1;
                            if (st_q.bit_cnt == 3'h7) begin
                                st_d.first = 1'b0;
                                if (st_q.first) begin
                                    st_d.is_read = rx_byte[DIR_BIT];
                                    st_d.waddr   = rx_byte[ADDR_MSB:ADDR_LSB];
                                    if (rx_byte[DIR_BIT]) begin
                                        st_d.push      = 1'b1;
                                        st_d.push_data = {1'b0, rx_byte[ADDR_MSB:ADDR_LSB],
                                                          MISO_IDLE};
                                    end
                                end else if (st_q.is_read) begin
                                    // Zero byte fetches nothing; a later non-zero byte in the burst fetches again
                                    if (rx_byte != 8'h00) begin
                                        st_d.push      = 1'b1;
                                        st_d.push_data = {1'b0, rx_byte[ADDR_MSB:ADDR_LSB],
                                                          MISO_IDLE};
                                    end
                                end else begin
                                    st_d.push      = 1'b1;
                                    st_d.push_data = {1'b1, st_q.waddr, rx_byte};
                                end
                            end
                        end
                        if (sck_fall) begin
                            // Load next byte at byte boundary, else shift
                            if (st_q.bit_cnt == 3'h0) begin
                                st_d.miso  = st_q.is_read && !st_q.first ?
                                             st_q.rd_buf[BYTE_W-1] : 1'b0;
                                st_d.tx_sh = st_q.is_read && !st_q.first ?
                                             {st_q.rd_buf[BYTE_W-2:0], 1'b0} : MISO_IDLE;
                            end else begin
                                st_d.miso  = st_q.tx_sh[BYTE_W-1];
                                st_d.tx_sh = {st_q.tx_sh[BYTE_W-2:0], 1'b0};
                            end
                        end
                    end
                end else begin
                    st_d.miso_oe = 1'b0;
                end
                if (reg_rd_valid) begin
                    st_d.rd_buf = reg_rd_data;
                end
            end
            default: begin
                st_d.state = ST_SETTLE;
            end
        endcase
        // Registered request output stage
        if (f_ready) begin
            st_d.req_valid = f_valid;
            if (f_valid) begin
                st_d.req_data = f_data;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_q       <= '0;
            st_q.state <= ST_SETTLE;
            st_q.mode  <= HOST_NONE;
            st_q.first <= 1'b1;
            st_q.sck_prev <= 1'b0;
            st_q.ss_prev  <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from state flops
    assign host_mode                = st_q.mode;
    assign mode_valid               = (st_q.state == ST_RUN);
    assign i2c_addr_extension_strap = st_q.ea;
    assign miso_out                 = st_q.miso;
    assign miso_oe                  = st_q.miso_oe;
    assign reg_req_valid            = st_q.req_valid;
    assign reg_req_write            = st_q.req_data[REQ_W-1];
    assign reg_req_addr             = st_q.req_data[REQ_W-2:BYTE_W];
    assign reg_req_wdata            = st_q.req_data[BYTE_W-1:0];
endmodule

// File: verification/host_port_asserts.sv
// Port checks for the host port detector and serial slave
`timescale 1ns/1ps
module host_port_asserts
    import host_port_pkg::*;
(
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  rst_b,
    // Straps and link pins
    input wire logic                  latch_pin,
    input wire logic [5:0]            addr_strap,
    input wire logic                  read_strobe_n,
    input wire logic                  write_strobe_n,
    input wire logic [6:5]            data_pin_in,
    input wire logic                  miso_out,
    input wire logic                  miso_oe,
    // Detection result
    input wire host_mode_e            host_mode,
    input wire logic                  mode_valid,
    input wire logic                  i2c_addr_extension_strap,
    // Register side
    input wire logic                  reg_req_valid,
    input wire logic                  reg_req_ready,
    input wire logic                  reg_req_write,
    input wire logic [REG_ADDR_W-1:0] reg_req_addr,
    input wire logic [BYTE_W-1:0]     reg_req_wdata,
    input wire logic                  reg_rd_valid,
    input wire logic [BYTE_W-1:0]     reg_rd_data
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Detection: quiet in reset, bounded start, then frozen
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> host_mode == HOST_NONE && !mode_valid && !reg_req_valid && !miso_oe)
        else $error("outputs not quiet after a reset edge");
    a_valid_soon: assert property ($rose(rst_b) |-> ##[1:8] mode_valid)
        else $error("detection result late");
    a_mode_kept: assert property (mode_valid |=> mode_valid && $stable(host_mode))
        else $error("mode changed without reset");
    a_spi_pick: assert property ($rose(mode_valid) && read_strobe_n && write_strobe_n && !latch_pin
        && addr_strap == STRAP_SPI |-> host_mode == HOST_SPI) else $error("spi straps not seen");
    a_uart_pick: assert property ($rose(mode_valid) && read_strobe_n && write_strobe_n && !latch_pin
        && addr_strap == STRAP_UART |-> host_mode == HOST_UART) else $error("uart straps not seen");
    a_ded_pick: assert property ($rose(mode_valid) && latch_pin |-> host_mode == HOST_PAR_DED)
        else $error("latch strap not seen");
    a_ext_only_i2c: assert property (mode_valid && host_mode != HOST_I2C |-> !i2c_addr_extension_strap)
        else $error("extension strap outside i2c mode");
    // Link pins: driver only in serial slave mode, quiet when deselected
    a_oe_spi_only: assert property (miso_oe |-> host_mode == HOST_SPI)
        else $error("data out driven outside spi mode");
    a_oe_deselect: assert property (latch_pin [*5] |-> !miso_oe)
        else $error("data out driven while deselected");
    a_miso_on_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso_out)
        |-> !$past(data_pin_in[5])) else $error("data out moved while clock high");
    // Requests hold until taken; reads carry no data
    a_req_held: assert property (reg_req_valid && !reg_req_ready |=> reg_req_valid
        && $stable({reg_req_write, reg_req_addr, reg_req_wdata})) else $error("request dropped");
    a_read_nodata: assert property (reg_req_valid && !reg_req_write |-> reg_req_wdata == 8'h00)
        else $error("read request carries data");
    c_write_taken: cover property (reg_req_valid && reg_req_ready && reg_req_write);
    c_read_back: cover property (reg_rd_valid && miso_oe);
    c_i2c_found: cover property ($rose(mode_valid) && host_mode == HOST_I2C);
endmodule
bind host_port_detect_spi_slave host_port_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .latch_pin(latch_pin), .addr_strap(addr_strap), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .data_pin_in(data_pin_in), .miso_out(miso_out),
    .miso_oe(miso_oe), .host_mode(host_mode), .mode_valid(mode_valid),
    .i2c_addr_extension_strap(i2c_addr_extension_strap), .reg_req_valid(reg_req_valid),
    .reg_req_ready(reg_req_ready), .reg_req_write(reg_req_write), .reg_req_addr(reg_req_addr),
    .reg_req_wdata(reg_req_wdata), .reg_rd_valid(reg_rd_valid), .reg_rd_data(reg_rd_data));

// File: verification/spi_master_model.sv
// Serial master stand-in for the host side of the slave link
`timescale 1ns/1ps
module spi_master_model #(
    parameter int LOW_NS  = 220,
    parameter int HIGH_NS = 100,
    parameter int LAST_NS = 800
) (
    // Link toward the slave
    output logic      sck,
    output logic      mosi,
    output logic      select_n,
    input  wire logic miso
);
    // Clock rests low outside frames; 320 ns period stays under the rate cap
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        select_n = 1'b1;
    end
    // Open or close a frame; a released data line shows its inverse
    task automatic frame(input logic open);
        #(LOW_NS);
        select_n = !open;
        if (!open) begin
            mosi = !mosi;
        end
    endtask
    // Shift out and in; last high phase stretched so a slow core can answer
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        int i;
        rx = 8'h00;
        for (i = 0; i < nbits; i++) begin
            mosi = tx[7 - i];
            #(LOW_NS);
            rx[7 - i] = miso;
            sck = 1'b1;
            #(i == 7 ? LAST_NS : HIGH_NS);
            sck = 1'b0;
        end
    endtask
    // Clock pulses with select high, data line wandering
    task automatic idle_clocks(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            #(LOW_NS);
            sck = 1'b1;
            mosi = !mosi;
            #(HIGH_NS);
            sck = 1'b0;
        end
    endtask
endmodule

// File: verification/tb_top.sv
// Self-checking bench for the host port detector and serial slave
`timescale 1ns/1ps
module tb_top;
    import host_port_pkg::*;
    localparam int FILL_DEPTH = 4;
    logic       clk_sys, rst_b, latch_strap, use_strap, read_strobe_n, write_strobe_n;
    logic [5:0] addr_strap, rd_addr, reg_req_addr;
    logic       reg_req_ready, reg_rd_valid, rd_pend, reg_req_valid, reg_req_write;
    logic [7:0] reg_rd_data, rx, reg_req_wdata;
    logic [7:0] regs [64];
    logic       sck, mosi, select_n, miso_out, miso_oe, mode_valid, i2c_ext;
    wire        latch_pin;
    host_mode_e host_mode;
    int         errors, samples_checked, wr_count, rd_count;

    // Select line doubles as strap while detection runs
    assign latch_pin = use_strap ? latch_strap : select_n;

    host_port_detect_spi_slave #(.DEPTH(FILL_DEPTH)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .latch_pin(latch_pin), .addr_strap(addr_strap),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .data_pin_in({mosi, sck}), .miso_out(miso_out), .miso_oe(miso_oe),
        .host_mode(host_mode), .mode_valid(mode_valid), .i2c_addr_extension_strap(i2c_ext),
        .reg_req_valid(reg_req_valid), .reg_req_ready(reg_req_ready),
        .reg_req_write(reg_req_write), .reg_req_addr(reg_req_addr),
        .reg_req_wdata(reg_req_wdata), .reg_rd_valid(reg_rd_valid), .reg_rd_data(reg_rd_data));
    spi_master_model u_master (.sck(sck), .mosi(mosi), .select_n(select_n), .miso(miso_out));

    // Register core stand-in: stores writes, answers reads on the next cycle
    always @(posedge clk_sys) begin
        if (rst_b && reg_req_valid === 1'b1 && reg_req_ready) begin
            if (reg_req_write) begin
                regs[reg_req_addr] = reg_req_wdata;
                wr_count++;
            end else begin
                rd_pend = 1'b1;
                rd_addr = reg_req_addr;
                rd_count++;
            end
        end
    end
    always @(negedge clk_sys) begin
        reg_rd_valid <= rd_pend;
        reg_rd_data <= rd_pend ? regs[rd_addr] : 8'h00;
        rd_pend = 1'b0;
    end

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Reset with given straps; afterwards the straps drift and the choice must stay
    task automatic detect_case(input logic l, rs, ws, input logic [5:0] a,
                               input host_mode_e m, input logic e);
        int i;
        @(negedge clk_sys);
        rst_b = 1'b0;
        use_strap = 1'b1;
        latch_strap = l;
        read_strobe_n = rs;
        write_strobe_n = ws;
        addr_strap = a;
        repeat (16) @(negedge clk_sys);
        rst_b = 1'b1;
        for (i = 0; i < 20 && mode_valid !== 1'b1; i++) @(negedge clk_sys);
        if (mode_valid !== 1'b1) begin
            errors++;
            report_and_stop();
        end
        repeat (6) @(negedge clk_sys);
        use_strap = 1'b0;
        addr_strap = 6'h3F;
        repeat (10) @(negedge clk_sys);
        check_val({5'h00, host_mode}, {5'h00, m});
        check_val({7'h00, i2c_ext}, {7'h00, e});
    endtask
    // Read burst over three addresses, closed by a zero byte
    task automatic read_burst();
        int base;
        base = rd_count;
        u_master.frame(1'b1);
        u_master.xfer(8'h82, 8, rx);
        check_val({7'h00, miso_oe}, 8'h01);
        u_master.xfer(8'h8A, 8, rx);
        check_val(rx, 8'hA5);
        u_master.xfer(8'hFE, 8, rx);
        check_val(rx, 8'h3C);
        u_master.xfer(8'h00, 8, rx);
        check_val(rx, 8'h81);
        u_master.frame(1'b0);
        repeat (6) @(negedge clk_sys);
        check_val({7'h00, miso_oe}, 8'h00);
        check_val(8'(rd_count - base), 8'h03);
    endtask
    // Write burst against a stalled core: fill until refused, then drain
    task automatic write_stall();
        int base;
        int i;
        base = wr_count;
        @(negedge clk_sys);
        reg_req_ready = 1'b0;
        u_master.frame(1'b1);
        for (i = 0; i < 8; i++) begin
            u_master.xfer(i == 0 ? 8'h14 : 8'(i * 17), 8, rx);
            check_val(rx, MISO_IDLE);
        end
        u_master.frame(1'b0);
        repeat (20) @(negedge clk_sys);
        check_val(8'(wr_count - base), 8'h00);
        reg_req_ready = 1'b1;
        for (i = 0; i < 60 && wr_count - base < FILL_DEPTH + 1; i++) @(negedge clk_sys);
        repeat (10) @(negedge clk_sys);
        check_val(8'(wr_count - base), 8'(FILL_DEPTH + 1));
        check_val(regs[6'h0A], 8'h55);
        check_val(regs[6'h0B], 8'h00);
    endtask
    // Broken frame and clocks while deselected must not upset the next frame
    task automatic abort_then_read();
        u_master.frame(1'b1);
        u_master.xfer(8'hFF, 3, rx);
        u_master.frame(1'b0);
        u_master.idle_clocks(8);
        u_master.frame(1'b1);
        u_master.xfer(8'h94, 8, rx);
        u_master.xfer(8'h00, 8, rx);
        check_val(rx, 8'h55);
        u_master.frame(1'b0);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Hang guard
    initial begin
        #3_000_000;
        errors++;
        report_and_stop();
    end
    initial begin
        rst_b = 1'b0;
        use_strap = 1'b1;
        latch_strap = 1'b0;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        addr_strap = 6'h00;
        reg_req_ready = 1'b1;
        reg_rd_valid = 1'b0;
        reg_rd_data = 8'h00;
        rd_pend = 1'b0;
        errors = 0;
        samples_checked = 0;
        wr_count = 0;
        rd_count = 0;
        foreach (regs[i]) regs[i] = 8'h00;
        regs[1] = 8'hA5;
        regs[5] = 8'h3C;
        regs[63] = 8'h81;
        detect_case(1'b0, 1'b1, 1'b1, 6'h00, HOST_UART, 1'b0);
        detect_case(1'b0, 1'b1, 1'b1, 6'h02, HOST_I2C, 1'b0);
        detect_case(1'b0, 1'b1, 1'b1, 6'h03, HOST_I2C, 1'b1);
        detect_case(1'b0, 1'b1, 1'b1, 6'h07, HOST_PAR_MUX_SEP, 1'b0);
        detect_case(1'b0, 1'b1, 1'b1, 6'h06, HOST_PAR_MUX_COM, 1'b0);
        detect_case(1'b1, 1'b1, 1'b1, 6'h15, HOST_PAR_DED, 1'b0);
        detect_case(1'b0, 1'b0, 1'b1, 6'h01, HOST_NONE, 1'b0);
        detect_case(1'b0, 1'b1, 1'b1, 6'h01, HOST_SPI, 1'b0);
        read_burst();
        write_stall();
        abort_then_read();
        report_and_stop();
    end
endmodule
